// File: pdm_defines.vh
// Constants for the processor datapath multiplexer and register block.
// Assumes inclusion by bare name from the datapath module file.
`ifndef PDM_DEFINES_VH
`define PDM_DEFINES_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PDM_DW 16
`define PDM_AW 18
`define PDM_PW 9
`define PDM_PSW 8
`define PDM_RBW 5
`define PDM_SPD 16

// ----------------------------------------------------------------------
// Destination selector codes
// ----------------------------------------------------------------------
`define PDM_DSEL_READ_BUS 2'h0
`define PDM_DSEL_RESULT 2'h1
`define PDM_DSEL_RESULT_SHR 2'h2
`define PDM_DSEL_SYS_BUS 2'h3

// ----------------------------------------------------------------------
// Timing pulse codes used by the clock enable gates
// ----------------------------------------------------------------------
`define PDM_PULSE_FIRST 2'h1
`define PDM_PULSE_SECOND 2'h2
`define PDM_PULSE_THIRD 2'h3
`define PDM_PULSE_IR `PDM_PULSE_THIRD
`define PDM_PULSE_BA `PDM_PULSE_SECOND
`define PDM_PULSE_B `PDM_PULSE_THIRD
`define PDM_PULSE_RESULT `PDM_PULSE_SECOND
`define PDM_PULSE_SCRATCH `PDM_PULSE_THIRD
`define PDM_PULSE_PS `PDM_PULSE_THIRD

// ----------------------------------------------------------------------
// Processor register addresses seen on the bus address register
// ----------------------------------------------------------------------
`define PDM_ADDR_PS 18'h3fffe
`define PDM_ADDR_LIMIT 18'h3fffa
`define PDM_ADDR_SWITCH 18'h3ff78
`define PDM_ADDR_SCRATCH_BASE 18'h3ff00
`define PDM_ADDR_SCRATCH_MASK 18'h3ffe0
`define PDM_RED_ZONE 18'h00020

// ----------------------------------------------------------------------
// Software register indices (byte address = word offset)
// ----------------------------------------------------------------------
`define PDM_REG_STATUS 5'h00
`define PDM_REG_MASK 5'h04
`define PDM_REG_STACK_LIMIT 5'h08
`define PDM_REG_SWITCH 5'h0c
`define PDM_REG_INSTR 5'h10
`define PDM_REG_RESULT 5'h14
`define PDM_REG_STATE 5'h18

// ----------------------------------------------------------------------
// Event bits and reset values
// ----------------------------------------------------------------------
`define PDM_EV_W 3
`define PDM_EV_OVFL 0
`define PDM_EV_HALT 1
`define PDM_EV_IRLD 2
`define PDM_EV_ZERO 3'h0
`define PDM_RST_DATA 16'h0000
`define PDM_RST_ADDR 18'h00000
`define PDM_RST_PTR 9'h000
`define PDM_RST_PS 8'h00
`define PDM_RST_LIMIT 16'h0000
`define PDM_RST_WORD 32'h0000_0000
`define PDM_IR_REG_LSB 0
`define PDM_IR_REG_MSB 3
`define PDM_IR_BR_LSB 6
`define PDM_IR_BR_MSB 11

`endif

// File: pdm_datapath.v
// Datapath slice: clock enable gates, destination selector, result and
// instruction registers, address and data decoding, pointer drivers.
// Assumes the sequencer gives one-cycle timing pulses synchronous to
// core_clk_i and the microword fields stay steady around each pulse.
//
// Overview of operation
// RULE1: Register loads derive from chosen timing pulse
// RULE2: Load only when microword enable bit set
// RULE3: Two-bit field selects four data sources
// RULE4: Selector output feeds registers, display, bus
// RULE5: Result register captures ALU output
// RULE6: Result drives selector and system bus data
// RULE7: Console indicators show selector output inverted
// RULE8: Decoder examines bus address and result
// RULE9: Distinct selects: status, limit, scratch, switches
// RULE10: Detect stack overflow; flag and halt
// RULE11: Zero detect when result all zero
// RULE12: Pointer buffered to history and expansion
// RULE13: Instruction register holds sixteen bits
// RULE14: Instruction register loads selector output on fetch
// RULE15: Instruction register feeds instruction decode
// RULE16: Instruction bits drive microbranch and scratch select
// RULE17: Read bus ORs scratch, status, option data
// RULE18: History register captures pointer every clock
// RULE19: Shift-right input moves result toward bit zero
`timescale 1ns/1ps
`include "pdm_defines.vh"
`default_nettype none

module pdm_datapath (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Timing pulses from the pulse generator
  input wire first_timing_pulse_i,
  input wire second_timing_pulse_i,
  input wire third_timing_pulse_i,
  // Microword load enables
  input wire instruction_load_enable_i,
  input wire bus_address_load_enable_i,
  input wire operand_b_load_enable_i,
  input wire result_load_enable_i,
  input wire scratch_write_high_i,
  input wire scratch_write_low_i,
  input wire status_load_enable_i,
  input wire [1:0] destination_selector_i,
  input wire scratch_read_enable_i,
  input wire status_read_enable_i,
  input wire stack_reference_i,
  input wire shift_in_i,
  // Data sources
  input wire [`PDM_DW-1:0] alu_result_i,
  input wire [`PDM_DW-1:0] system_bus_data_i,
  input wire [`PDM_DW-1:0] option_data_i,
  input wire [`PDM_AW-1:0] bus_address_next_i,
  input wire [`PDM_PW-1:0] microprogram_pointer_i,
  // Software register port
  input wire [`PDM_RBW-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [31:0] reg_rdata_o,
  // Datapath outputs
  output wire [`PDM_DW-1:0] internal_data_bus_o,
  output wire [`PDM_DW-1:0] read_bus_o,
  output wire [`PDM_DW-1:0] system_bus_data_o,
  output wire [`PDM_DW-1:0] console_data_n_o,
  output wire [`PDM_DW-1:0] operand_b_o,
  output wire [`PDM_AW-1:0] bus_address_o,
  output wire [`PDM_PSW-1:0] status_word_o,
  output wire [`PDM_DW-1:0] instruction_holding_reg_o,
  output wire [`PDM_IR_BR_MSB-`PDM_IR_BR_LSB:0] microbranch_bits_o,
  output wire [`PDM_PW-1:0] past_pointer_history_o,
  output wire [`PDM_PW-1:0] buffered_pointer_copy_o,
  output wire [`PDM_PW-1:0] expansion_pointer_copy_o,
  // Decoder outputs
  output wire status_select_o,
  output wire stack_limit_select_o,
  output wire scratch_select_o,
  output wire console_switch_select_o,
  output wire stack_overflow_flag_o,
  output wire stack_overflow_halt_o,
  output wire result_zero_o,
  // Interrupt
  output wire irq_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Chosen pulse for a register's load; code 0 means no pulse
  function pulse_pick;
    input [1:0] code;
    input pa;
    input pb;
    input pc;
    begin
      case (code)
        `PDM_PULSE_FIRST: pulse_pick = pa;
        `PDM_PULSE_SECOND: pulse_pick = pb;
        `PDM_PULSE_THIRD: pulse_pick = pc;
        default: pulse_pick = 1'b0;
      endcase
    end
  endfunction

  // Match of an address against a processor register address, compared under a mask
  function addr_hit;
    input [`PDM_AW-1:0] addr;
    input [`PDM_AW-1:0] target;
    input [`PDM_AW-1:0] mask;
    begin
      addr_hit = ((addr & mask) == (target & mask));
    end
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg [`PDM_DW-1:0] result_ff;
  reg [`PDM_DW-1:0] instr_ff;
  reg [`PDM_DW-1:0] operand_b_ff;
  reg [`PDM_AW-1:0] bus_addr_ff;
  reg [`PDM_PSW-1:0] status_ff;
  reg [`PDM_PW-1:0] past_ptr_ff;
  reg [`PDM_DW-1:0] display_n_ff;
  reg [`PDM_DW-1:0] scratch_mem [0:`PDM_SPD-1];
  reg [`PDM_EV_W-1:0] event_ff;
  reg [`PDM_EV_W-1:0] mask_ff;
  reg [`PDM_DW-1:0] limit_ff;
  reg [`PDM_DW-1:0] switch_ff;
  reg [31:0] nxt_rdata;
  reg [`PDM_DW-1:0] dmux;
  wire [`PDM_EV_W-1:0] ev_set;
  wire [`PDM_EV_W-1:0] ev_clr;

  // ----------------------------------------------------------------------
  // Clock enable gates
  // ----------------------------------------------------------------------
  // Single clock design: the gated clocks become one-cycle load strobes,
  // which avoids skew between gated clock trees at the cost of a pulse
  // input that must be synchronous.
  wire tpa = first_timing_pulse_i;
  wire tpb = second_timing_pulse_i;
  wire tpc = third_timing_pulse_i;
  wire ld_ir = instruction_load_enable_i & pulse_pick(`PDM_PULSE_IR, tpa, tpb, tpc); // RULE1 RULE2
  wire ld_ba = bus_address_load_enable_i & pulse_pick(`PDM_PULSE_BA, tpa, tpb, tpc); // RULE1 RULE2
  wire ld_b = operand_b_load_enable_i & pulse_pick(`PDM_PULSE_B, tpa, tpb, tpc); // RULE1 RULE2
  wire ld_res = result_load_enable_i & pulse_pick(`PDM_PULSE_RESULT, tpa, tpb, tpc); // RULE1 RULE2
  wire sp_pulse = pulse_pick(`PDM_PULSE_SCRATCH, tpa, tpb, tpc); // RULE1
  wire wr_hi = scratch_write_high_i & sp_pulse; // RULE2
  wire wr_lo = scratch_write_low_i & sp_pulse; // RULE2
  wire ld_ps = status_load_enable_i & pulse_pick(`PDM_PULSE_PS, tpa, tpb, tpc); // RULE1

  // ----------------------------------------------------------------------
  // Register read bus
  // ----------------------------------------------------------------------
  // Scratch pad word picked by low instruction bits
  wire [`PDM_IR_REG_MSB:0] sp_index = instr_ff[`PDM_IR_REG_MSB:`PDM_IR_REG_LSB]; // RULE16
  wire [`PDM_DW-1:0] sp_rd = scratch_mem[sp_index];
  wire [`PDM_DW-1:0] sp_term = scratch_read_enable_i ? sp_rd : `PDM_RST_DATA;
  wire [`PDM_DW-1:0] ps_term = status_read_enable_i ?
    {{(`PDM_DW-`PDM_PSW){1'b0}}, status_ff} : `PDM_RST_DATA;
  // Wired-OR of all three drivers, as the open-collector bus did
  wire [`PDM_DW-1:0] read_bus = sp_term | ps_term | option_data_i; // RULE17
  assign read_bus_o = read_bus; // RULE17

  // ----------------------------------------------------------------------
  // Destination selector
  // ----------------------------------------------------------------------
  // Shifted input: top bit comes from outside shift logic
  wire [`PDM_DW-1:0] result_shr = {shift_in_i, result_ff[`PDM_DW-1:1]}; // RULE19

  always @*
  begin
    case (destination_selector_i) // RULE3
      `PDM_DSEL_READ_BUS: dmux = read_bus;
      `PDM_DSEL_RESULT: dmux = result_ff;
      `PDM_DSEL_RESULT_SHR: dmux = result_shr;
      `PDM_DSEL_SYS_BUS: dmux = system_bus_data_i;
      default: dmux = read_bus;
    endcase
  end

  assign internal_data_bus_o = dmux; // RULE4

  // ----------------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------------
  // Result, instruction, B, bus address and status registers
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      result_ff <= `PDM_RST_DATA;
      instr_ff <= `PDM_RST_DATA;
      operand_b_ff <= `PDM_RST_DATA;
      bus_addr_ff <= `PDM_RST_ADDR;
      status_ff <= `PDM_RST_PS;
    end
    else
    begin
      if (ld_res)
        result_ff <= alu_result_i; // RULE5
      if (ld_ir)
        instr_ff <= dmux; // RULE4 RULE13 RULE14
      if (ld_b)
        operand_b_ff <= dmux; // RULE4
      if (ld_ba)
        bus_addr_ff <= bus_address_next_i;
      if (ld_ps)
        status_ff <= dmux[`PDM_PSW-1:0]; // RULE4
    end
  end

  // Scratch pad has no reset; byte strobes write each half alone
  always @(posedge core_clk_i)
  begin
    if (wr_hi)
      scratch_mem[sp_index][`PDM_DW-1:`PDM_PSW] <= dmux[`PDM_DW-1:`PDM_PSW]; // RULE4
    if (wr_lo)
      scratch_mem[sp_index][`PDM_PSW-1:0] <= dmux[`PDM_PSW-1:0]; // RULE4
  end

  // History register and console display follow every clock
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      past_ptr_ff <= `PDM_RST_PTR;
      display_n_ff <= ~`PDM_RST_DATA;
    end
    else
    begin
      past_ptr_ff <= buffered_pointer_copy_o; // RULE18
      display_n_ff <= ~dmux; // RULE7
    end
  end

  assign system_bus_data_o = result_ff; // RULE6
  assign console_data_n_o = display_n_ff;
  assign operand_b_o = operand_b_ff;
  assign bus_address_o = bus_addr_ff;
  assign status_word_o = status_ff;
  assign instruction_holding_reg_o = instr_ff; // RULE15
  assign microbranch_bits_o = instr_ff[`PDM_IR_BR_MSB:`PDM_IR_BR_LSB]; // RULE16
  assign past_pointer_history_o = past_ptr_ff;

  // ----------------------------------------------------------------------
  // Pointer drivers
  // ----------------------------------------------------------------------
  // Pure fan-out; no storage so the copies track the pointer at once
  assign buffered_pointer_copy_o = microprogram_pointer_i; // RULE12
  assign expansion_pointer_copy_o = microprogram_pointer_i; // RULE12

  // ----------------------------------------------------------------------
  // Address and data decoding
  // ----------------------------------------------------------------------
  wire [`PDM_AW-1:0] full_mask = {`PDM_AW{1'b1}};
  assign status_select_o = addr_hit(bus_addr_ff, `PDM_ADDR_PS, full_mask); // RULE8 RULE9
  assign stack_limit_select_o = addr_hit(bus_addr_ff, `PDM_ADDR_LIMIT, full_mask); // RULE9
  assign scratch_select_o = addr_hit(bus_addr_ff, `PDM_ADDR_SCRATCH_BASE,
    `PDM_ADDR_SCRATCH_MASK); // RULE9
  assign console_switch_select_o = addr_hit(bus_addr_ff, `PDM_ADDR_SWITCH, full_mask); // RULE9

  // Stack reference below the limit warns; more than the red zone below it halts
  wire [`PDM_AW-1:0] limit_ext = {{(`PDM_AW-`PDM_DW){1'b0}}, limit_ff};
  wire below_limit = bus_addr_ff < limit_ext;
  wire [`PDM_AW:0] red_sum = {1'b0, bus_addr_ff} + {1'b0, `PDM_RED_ZONE};
  wire below_red = red_sum < {1'b0, limit_ext};
  assign stack_overflow_flag_o = stack_reference_i & below_limit; // RULE10
  assign stack_overflow_halt_o = stack_reference_i & below_red; // RULE10
  assign result_zero_o = (result_ff == `PDM_RST_DATA); // RULE8 RULE11

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  assign ev_set[`PDM_EV_OVFL] = stack_overflow_flag_o;
  assign ev_set[`PDM_EV_HALT] = stack_overflow_halt_o;
  assign ev_set[`PDM_EV_IRLD] = ld_ir;
  wire status_wr = reg_write_i & (reg_addr_i == `PDM_REG_STATUS);
  assign ev_clr = status_wr ? reg_wdata_i[`PDM_EV_W-1:0] : `PDM_EV_ZERO;

  // Set beats clear so an event in the clearing cycle is kept
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      event_ff <= `PDM_EV_ZERO;
    else
      event_ff <= (event_ff & ~ev_clr) | ev_set;
  end

  assign irq_o = |(event_ff & mask_ff);

  // ----------------------------------------------------------------------
  // Software register port
  // ----------------------------------------------------------------------
  // Writable control registers
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mask_ff <= `PDM_EV_ZERO;
      limit_ff <= `PDM_RST_LIMIT;
      switch_ff <= `PDM_RST_DATA;
    end
    else if (reg_write_i)
    begin
      case (reg_addr_i)
        `PDM_REG_MASK: mask_ff <= reg_wdata_i[`PDM_EV_W-1:0];
        `PDM_REG_STACK_LIMIT: limit_ff <= reg_wdata_i[`PDM_DW-1:0];
        `PDM_REG_SWITCH: switch_ff <= reg_wdata_i[`PDM_DW-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always @*
  begin
    nxt_rdata = `PDM_RST_WORD;
    if (reg_read_i)
    begin
      case (reg_addr_i)
        `PDM_REG_STATUS: nxt_rdata[`PDM_EV_W-1:0] = event_ff;
        `PDM_REG_MASK: nxt_rdata[`PDM_EV_W-1:0] = mask_ff;
        `PDM_REG_STACK_LIMIT: nxt_rdata[`PDM_DW-1:0] = limit_ff;
        `PDM_REG_SWITCH: nxt_rdata[`PDM_DW-1:0] = switch_ff;
        `PDM_REG_INSTR: nxt_rdata[`PDM_DW-1:0] = instr_ff;
        `PDM_REG_RESULT: nxt_rdata[`PDM_DW-1:0] = result_ff;
        `PDM_REG_STATE: nxt_rdata[`PDM_PW:0] = {result_zero_o, past_ptr_ff};
        default: nxt_rdata = `PDM_RST_WORD;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= `PDM_RST_WORD;
    else
      reg_rdata_o <= nxt_rdata;
  end

  // Console switch word is plain storage: software writes it and reads
  // it back; the bus side only sees its decode select.

endmodule

`default_nettype wire

// File: pdm_pulse_model.sv
// Sequencer stand-in: turns a request code into one timing pulse.
// Assumes one clock shared with the datapath; requests last one cycle.
`timescale 1ns/1ps
`default_nettype none
module pdm_pulse_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Request: 1..3 names the pulse, 0 is idle
  input wire logic [1:0] pulse_req_i,
  // Timing pulses
  output logic first_timing_pulse_o,
  output logic second_timing_pulse_o,
  output logic third_timing_pulse_o
);
  logic [1:0] req_ff;
  // Registered so the pulse lands a cycle after the microword settles
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      req_ff <= 2'h0;
    else
      req_ff <= pulse_req_i;
  end
  // One line high per cycle at most; a held request repeats the pulse
  assign first_timing_pulse_o = (req_ff == 2'h1);
  assign second_timing_pulse_o = (req_ff == 2'h2);
  assign third_timing_pulse_o = (req_ff == 2'h3);
endmodule
`default_nettype wire

// File: pdm_datapath_sva.sv
// Port-level checker for the datapath slice.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "pdm_defines.vh"
`default_nettype none
module pdm_datapath_sva (
  // Clock, reset, controls
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic second_timing_pulse_i,
  input wire logic third_timing_pulse_i,
  input wire logic instruction_load_enable_i,
  input wire logic result_load_enable_i,
  input wire logic [1:0] destination_selector_i,
  // Data
  input wire logic [`PDM_DW-1:0] alu_result_i,
  input wire logic [`PDM_DW-1:0] system_bus_data_i,
  input wire logic [`PDM_PW-1:0] microprogram_pointer_i,
  input wire logic [`PDM_DW-1:0] internal_data_bus_o,
  input wire logic [`PDM_DW-1:0] system_bus_data_o,
  input wire logic [`PDM_DW-1:0] console_data_n_o,
  input wire logic [`PDM_AW-1:0] bus_address_o,
  input wire logic [`PDM_DW-1:0] instruction_holding_reg_o,
  input wire logic [5:0] microbranch_bits_o,
  input wire logic [`PDM_PW-1:0] past_pointer_history_o,
  input wire logic [`PDM_PW-1:0] buffered_pointer_copy_o,
  input wire logic [`PDM_PW-1:0] expansion_pointer_copy_o,
  // Decoder
  input wire logic status_select_o,
  input wire logic result_zero_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------------
  // Assertions; the $past(rst_i) guards skip the edge after reset
  // ------------------------------------------------------------------
  a_console_inverted: assert property (!$past(rst_i) |->
    console_data_n_o == ~$past(internal_data_bus_o)) else $error("console not inverted");
  a_result_capture: assert property (!$past(rst_i) && $past(result_load_enable_i &&
    second_timing_pulse_i) |-> system_bus_data_o == $past(alu_result_i))
    else $error("result not captured");
  a_result_holds: assert property (!(result_load_enable_i && second_timing_pulse_i)
    |=> $stable(system_bus_data_o)) else $error("result moved without load");
  a_zero_detect: assert property (result_zero_o == (system_bus_data_o == 16'h0000))
    else $error("zero detect wrong");
  a_sel_sysbus: assert property (destination_selector_i == 2'h3 |->
    internal_data_bus_o == system_bus_data_i) else $error("selector code 3 wrong");
  a_sel_result: assert property (destination_selector_i == 2'h1 |->
    internal_data_bus_o == system_bus_data_o) else $error("selector code 1 wrong");
  a_ir_load: assert property (!$past(rst_i) && $past(instruction_load_enable_i &&
    third_timing_pulse_i) |-> instruction_holding_reg_o == $past(internal_data_bus_o))
    else $error("instruction load wrong");
  a_branch_bits: assert property (microbranch_bits_o ==
    instruction_holding_reg_o[11:6]) else $error("branch bits wrong");
  a_history_capture: assert property (!$past(rst_i) |->
    past_pointer_history_o == $past(microprogram_pointer_i)) else $error("history wrong");
  a_pointer_copies: assert property (buffered_pointer_copy_o == microprogram_pointer_i &&
    expansion_pointer_copy_o == microprogram_pointer_i) else $error("pointer copy wrong");
  a_status_decode: assert property (status_select_o ==
    (bus_address_o == `PDM_ADDR_PS)) else $error("status select wrong");
endmodule
bind pdm_datapath pdm_datapath_sva u_sva (.*);
`default_nettype wire

// File: processor_datapath_mux_regs_tb.sv
// Self-checking bench for the datapath slice and its register port.
// Assumes the pulse model drives the timing pulses and the bench the rest.
`timescale 1ns/1ps
`default_nettype none
module processor_datapath_mux_regs_tb;
  logic clk = 1'b0, rst = 1'b1, ir_en = 0, ba_en = 0, b_en = 0, res_en = 0, swh = 0, swl = 0;
  logic st_en = 0, srd = 0, strd = 0, sref = 0, shin = 0, wr_s = 0, rd_s = 0;
  logic [1:0] req = 2'h0, sel = 2'h0;
  logic [15:0] alu = 16'h0, sbus = 16'h0, opt = 16'h0;
  logic [17:0] ba = 18'h0;
  logic [8:0] ptr = 9'h0;
  logic [4:0] ra = 5'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] exp_sel [4] = '{16'h1000, 16'h1234, 16'h891a, 16'ha5c3};
  logic [17:0] dec_addr [4] = '{18'h3fffe, 18'h3fffa, 18'h3ff1f, 18'h3ff78};
  wire [31:0] rdat;
  wire tpa, tpb, tpc, zero, irq, ss, ls, scs, cs, ov, oh;
  wire [15:0] idb, rbus, sbo, con, opb, ir;
  wire [17:0] bao;
  wire [7:0] psw;
  wire [5:0] ubr;
  wire [8:0] hist, bcp, ecp;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // ------------------------------------------------------------------
  // Clock, partner and device
  // ------------------------------------------------------------------
  always #2 clk = ~clk;
  pdm_pulse_model u_seq (.core_clk_i(clk), .rst_i(rst), .pulse_req_i(req),
    .first_timing_pulse_o(tpa), .second_timing_pulse_o(tpb), .third_timing_pulse_o(tpc));
  pdm_datapath u_dut (.core_clk_i(clk), .rst_i(rst), .first_timing_pulse_i(tpa),
    .second_timing_pulse_i(tpb), .third_timing_pulse_i(tpc), .instruction_load_enable_i(ir_en),
    .bus_address_load_enable_i(ba_en), .operand_b_load_enable_i(b_en),
    .result_load_enable_i(res_en), .scratch_write_high_i(swh), .scratch_write_low_i(swl),
    .status_load_enable_i(st_en), .destination_selector_i(sel), .scratch_read_enable_i(srd),
    .status_read_enable_i(strd), .stack_reference_i(sref), .shift_in_i(shin),
    .alu_result_i(alu), .system_bus_data_i(sbus), .option_data_i(opt),
    .bus_address_next_i(ba), .microprogram_pointer_i(ptr), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdat), .internal_data_bus_o(idb),
    .read_bus_o(rbus), .system_bus_data_o(sbo), .console_data_n_o(con), .operand_b_o(opb),
    .bus_address_o(bao), .status_word_o(psw), .instruction_holding_reg_o(ir),
    .microbranch_bits_o(ubr), .past_pointer_history_o(hist), .buffered_pointer_copy_o(bcp),
    .expansion_pointer_copy_o(ecp), .status_select_o(ss), .stack_limit_select_o(ls),
    .scratch_select_o(scs), .console_switch_select_o(cs), .stack_overflow_flag_o(ov),
    .stack_overflow_halt_o(oh), .result_zero_o(zero), .irq_o(irq));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t mismatch got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdat, exp);
  endtask
  // Microword enables must already stand; the pulse lands one cycle later
  task automatic pulse(input logic [1:0] k);
    req <= k;
    @(posedge clk);
    req <= 2'h0;
    @(posedge clk);
    #1;
  endtask
  // Hang guard sized well above the fewer than a hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk(con, 16'hffff);
    chk({zero, irq}, 2'b10);
    alu <= 16'h1234;
    res_en <= 1'b1;
    pulse(2'h2);
    chk(sbo, 16'h1234);
    chk(zero, 1'b0);
    alu <= 16'h5555;
    pulse(2'h3);
    pulse(2'h1);
    res_en <= 1'b0;
    pulse(2'h2);
    chk(sbo, 16'h1234);
    rd(5'h14, 32'h1234);
    opt <= 16'h1000;
    sbus <= 16'ha5c3;
    shin <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      sel <= i[1:0];
      @(posedge clk);
      #1 chk(idb, exp_sel[i]);
      chk(con, 16'hffff ^ exp_sel[i]);
    end
    ir_en <= 1'b1;
    b_en <= 1'b1;
    pulse(2'h3);
    ir_en <= 1'b0;
    b_en <= 1'b0;
    chk(ir, 16'ha5c3);
    chk(opb, 16'ha5c3);
    chk(ubr, 6'h17);
    rd(5'h10, 32'ha5c3);
    rd(5'h00, 32'h4);
    sbus <= 16'h5a7e;
    {swh, swl, st_en} <= 3'b111;
    pulse(2'h3);
    {swh, swl, st_en} <= 3'b000;
    chk(psw, 8'h7e);
    {srd, strd, sel} <= 4'b1100;
    opt <= 16'h8001;
    @(posedge clk);
    #1 chk(rbus, 16'hda7f);
    chk(idb, 16'hda7f);
    {swl, sel, sbus, strd} <= {1'b1, 2'h3, 16'h1234, 1'b0};
    pulse(2'h3);
    {swl, sel} <= 3'b000;
    @(posedge clk);
    #1 chk(rbus, 16'hda35);
    wr(5'h04, 32'h4);
    chk(irq, 1'b1);
    wr(5'h04, 32'h0);
    chk(irq, 1'b0);
    wr(5'h04, 32'h4);
    wr(5'h00, 32'h4);
    chk(irq, 1'b0);
    ba_en <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ba <= dec_addr[i];
      pulse(2'h2);
      chk(bao, dec_addr[i]);
      chk({ss, ls, scs, cs}, 4'h8 >> i);
    end
    wr(5'h08, 32'h100);
    sref <= 1'b1;
    ba <= 18'h000e0;
    pulse(2'h2);
    chk({ov, oh}, 2'b10);
    ba <= 18'h000df;
    pulse(2'h2);
    chk({ov, oh}, 2'b11);
    ba <= 18'h00100;
    pulse(2'h2);
    chk({ov, oh}, 2'b00);
    {sref, ba_en} <= 2'b00;
    rd(5'h00, 32'h3);
    wr(5'h00, 32'h3);
    rd(5'h00, 32'h0);
    rd(5'h1c, 32'h0);
    wr(5'h10, 32'hffff);
    rd(5'h10, 32'ha5c3);
    ptr <= 9'h1a5;
    #1 chk({bcp, ecp}, {9'h1a5, 9'h1a5});
    @(posedge clk);
    #1 chk(hist, 9'h1a5);
    alu <= 16'h0000;
    res_en <= 1'b1;
    pulse(2'h2);
    res_en <= 1'b0;
    chk(zero, 1'b1);
    rd(5'h18, 32'h3a5);
    @(posedge clk);
    #1 chk(rdat, 32'h0);
    wr(5'h0c, 32'h1234abcd);
    rd(5'h0c, 32'habcd);
    rd(5'h04, 32'h4);
    print_verdict();
  end
endmodule
`default_nettype wire
